// file: smc_master_model.sv
// Bus master model that issues address tenures and write data.
`timescale 1ns/100ps
module bus_master_model (
   // Bus signals.
   input wire logic clk,
   input wire logic ack_n,
   output logic start_n,
   output logic [31:0] addr,
   output logic [3:0] apar,
   output logic rd,
   output logic burst,
   output logic coh_n,
   output logic retry_n,
   output logic [63:0] wdata,
   output logic [7:0] dp
);
   logic acked;
   // Idle levels; coherency stays off on every tenure.
   initial begin
      {start_n, coh_n, retry_n, addr, apar, rd, burst, acked, dp} = {3'h7, 47'h0};
      wdata = 64'h0123456789ABCDEF;
   end
   // One tenure held until acknowledged or 12 clocks pass, with an optional retry in the window after it.
   task automatic issue(input logic [31:0] a, input logic r, b, input logic [3:0] bap, input logic [7:0] bdp,
      input logic rt);
      @(posedge clk);
      #1;
      {start_n, addr, rd, burst, acked} = {1'b0, a, r, b, 1'b0};
      for (int i = 0; i < 8; i++) dp[i] = ~^wdata[8*i+:8] ^ bdp[i];
      for (int i = 0; i < 4; i++) apar[i] = ~^a[8*i+:8] ^ bap[i];
      @(posedge clk);
      #1;
      start_n = 1'b1;
      for (int i = 0; i < 12 && !acked; i++) begin
         @(posedge clk);
         acked = !ack_n;
      end
      #1;
      retry_n = !(rt && acked);
      addr = ~a;
      @(posedge clk);
      #1;
      retry_n = 1'b1;
   endtask
endmodule

// file: smc_pair_buf.sv
// Two-entry data buffer with valid and ready on both sides.
`timescale 1ns/100ps
module mc_pair_buf #(
   parameter int W = 72
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data,
   // Fill level.
   output logic [1:0] count
);
   logic [W-1:0] mem_reg [2];
   logic head_reg;
   logic tail_reg;
   logic [1:0] count_reg;
   logic push;
   logic pop;

   // Full and empty come straight from the fill count.
   assign in_ready = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data = mem_reg[head_reg];
   assign count = count_reg;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage is written at the tail pointer.
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[tail_reg] <= in_data;
      end
   end

   // Pointers and count move with each push and pop.
   always_ff @(posedge clk) begin
      if (rst) begin
         head_reg <= 1'b0;
         tail_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) begin
            tail_reg <= !tail_reg;
         end
         if (pop) begin
            head_reg <= !head_reg;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 2'h1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 2'h1;
         end
      end
   end
endmodule

// file: smc_pkg.sv
// Constants, timing figures and state encodings shared by the memory controller files.
//
// Contract
// - Burst read beats follow on consecutive clocks.
// - Single-beat write runs read then write.
// - Next address may start SDRAM access early.
// - Open page hit skips row activation.
// - Timing: CL2, RCD2, RP2, RAS5, RC7, WR2.
// - Pipelined page-hit reads average 2.5 clocks.
// - Pipelined page-hit writes reach 2-1-1-1.
// - One to eight blocks, 72 bits wide.
// - Every component has four internal banks.
// - Bus slave only, never a master.
// - Acknowledge address at once when bus idle.
// - Otherwise acknowledge with or after last beat.
// - Start when target free, drive when granted.
// - Latch write data when buffer and bus allow.
// - Odd read parity per lane, forcible even.
// - Check write lanes, log, machine check.
// - Optional parity check on all bus transfers.
// - Check four address lanes every address phase.
// - Never drive address parity.
// - Retry suppresses read data and write commit.
// - Cache claim sampled second edge after start.
package mc_pkg;
   // SDRAM timing in clock periods.
   localparam logic [3:0] CAS_LAT = 4'h2;
   localparam logic [3:0] T_RCD = 4'h2;
   localparam logic [3:0] T_RP = 4'h2;
   localparam logic [3:0] T_RAS = 4'h5;
   localparam logic [3:0] T_RC = 4'h7;
   localparam logic [3:0] T_WR = 4'h2;
   localparam logic [3:0] CNT_SAT = 4'hF;
   localparam int RD_PIPE = 3;
   // Transfer shape.
   localparam logic [2:0] BURST_BEATS = 3'h4;
   localparam logic [2:0] SINGLE_BEATS = 3'h1;
   localparam logic [1:0] CLAIM_DELAY = 2'h2;
   localparam int LANES = 8;
   localparam int ADDR_LANES = 4;
   localparam int DATA_W = 64;
   localparam int SD_W = 72;
   localparam int NUM_BANKS = 4;
   // Address split: block, bank, row and beat column.
   localparam int BLK_LSB = 26;
   localparam int BANK_LSB = 24;
   localparam int ROW_LSB = 11;
   localparam int ROW_W = 13;
   localparam int COL_LSB = 3;
   localparam int COL_W = 8;
   // Read credits with and without the data bus granted.
   localparam logic [2:0] CREDIT_IDLE = 3'h2;
   localparam logic [2:0] CREDIT_GRANT = 3'h4;
   // SDRAM commands as {ras_n, cas_n, we_n}.
   localparam logic [2:0] CMD_NOP = 3'h7;
   localparam logic [2:0] CMD_ACT = 3'h3;
   localparam logic [2:0] CMD_READ = 3'h5;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_PRE = 3'h2;
   // Access engine states, Gray coded along the longest path, E_IDLE through E_PRE, E_ACT and E_RMW to E_RW.
   typedef enum logic [2:0] {
      E_IDLE = 3'h0,
      E_PRE = 3'h1,
      E_ACT = 3'h3,
      E_RMW = 3'h2,
      E_RW = 3'h6
   } eng_t;
endpackage

// file: system_memory_controller.sv
// Processor bus slave front end that runs SDRAM cycles with page holding and bus parity checks.
`timescale 1ns/100ps
module system_memory_controller
   import mc_pkg::*;
(
   // Clock and reset.
   input wire logic CLK,
   input wire logic RST,
   // Address tenure.
   input wire logic TRANSFER_START_N,
   input wire logic [31:0] ADDR,
   input wire logic [ADDR_LANES-1:0] ADDRESS_LANE_PARITY,
   input wire logic READ,
   input wire logic BURST,
   input wire logic [LANES-1:0] BYTE_EN,
   input wire logic GLOBAL_COHERENT_N,
   input wire logic CACHE_CLAIM_N,
   input wire logic ADDRESS_RETRY_N,
   output logic ADDRESS_ACKNOWLEDGE_N,
   // Data tenure.
   input wire logic DATA_BUS_GRANT_N,
   input wire logic OTHER_DATA_BUSY,
   input wire logic BUS_TA_N,
   input wire logic [DATA_W-1:0] DATA_IN,
   input wire logic [LANES-1:0] DATA_LANE_PARITY_IN,
   output logic TA_N,
   output logic DATA_OE,
   output logic [DATA_W-1:0] DATA_OUT,
   output logic [LANES-1:0] DATA_LANE_PARITY,
   // Configuration and status.
   input wire logic CACHE_PRESENT,
   input wire logic [LANES-1:0] FORCE_EVEN_PARITY,
   input wire logic CHECK_ALL_PARITY,
   input wire logic MCHECK_EN,
   input wire logic PARITY_LOG_CLR,
   output logic [ADDR_LANES-1:0] ADDR_PARITY_LOG,
   output logic [LANES-1:0] DATA_PARITY_LOG,
   output logic MCHECK_N,
   // SDRAM.
   output logic [7:0] SD_CS_N,
   output logic [2:0] SD_CMD,
   output logic [1:0] SD_BA,
   output logic [ROW_W-1:0] SD_A,
   output logic [SD_W-1:0] SD_DQ_OUT,
   output logic SD_DQ_OE,
   input wire logic [SD_W-1:0] SD_DQ_IN
);
   logic a_valid_reg, a_claimed_reg, a_taken_reg, a_aacked_reg, a_read_reg, a_burst_reg;
   logic [1:0] a_wait_reg;
   logic [31:0] a_addr_reg;
   logic [LANES-1:0] a_be_reg;
   logic dt_active_reg, dt_read_reg;
   logic [2:0] dt_left_reg;
   eng_t e_state_reg;
   logic [31:0] e_addr_reg;
   logic e_read_reg, e_wr_reg, e_abort_reg, rmw_sent_reg;
   logic [2:0] e_beats_reg, e_issued_reg;
   logic [LANES-1:0] e_be_reg;
   logic [DATA_W-1:0] merge_reg;
   logic [3:0] act_cnt_reg, pre_cnt_reg, wr_cnt_reg;
   logic [RD_PIPE-1:0] rd_pipe_reg;
   logic [NUM_BANKS-1:0] open_v_reg;
   logic [2:0] open_blk_reg [NUM_BANKS];
   logic [ROW_W-1:0] open_row_reg [NUM_BANKS];
   logic [ADDR_LANES-1:0] apar_log_reg;
   logic [LANES-1:0] dpar_log_reg;
   logic address_acknowledge_n_now, rd_ta, wr_ta, ta_now, dt_last_now, eng_take, page_hit, wr_clear;
   logic rd_arrive, issue_rd, issue_wr, rd_room;
   logic [2:0] cmd, inflight, blk_sel;
   logic [1:0] ba_sel;
   logic [ROW_W-1:0] a_sel;
   logic [DATA_W-1:0] wdata;
   logic [LANES-1:0] chk, gen_par, dpar_err;
   logic [ADDR_LANES-1:0] apar_err;
   logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
   logic [SD_W-1:0] buf_in_data, buf_out_data;
   logic [1:0] buf_count;
   logic [1:0] s_bank, e_bank;
   logic [2:0] s_blk;

   ////////////////////////////////////////////////////////////////////////////////
   // Address tenure. There is no address or address parity output: the block never masters.

   assign s_bank = a_addr_reg[BANK_LSB +: 2];
   assign s_blk = a_addr_reg[BLK_LSB +: 3];
   assign dt_last_now = ta_now && (dt_left_reg == SINGLE_BEATS);
   // Acknowledge at once on an idle bus, else with our own last beat; another slave's tenure holds it off.
   assign address_acknowledge_n_now = a_valid_reg && a_claimed_reg && a_taken_reg && !a_aacked_reg &&
      ((!dt_active_reg && !OTHER_DATA_BUSY) || dt_last_now);
   assign ADDRESS_ACKNOWLEDGE_N = !address_acknowledge_n_now;

   // The slot holds one request from its start through the retry window after acknowledge.
   always_ff @(posedge CLK) begin
      if (RST) begin
         a_valid_reg <= 1'b0;
         a_claimed_reg <= 1'b0;
         a_taken_reg <= 1'b0;
         a_aacked_reg <= 1'b0;
         a_wait_reg <= 2'h0;
      end else if (!a_valid_reg && !TRANSFER_START_N) begin
         a_valid_reg <= 1'b1;
         // The edge that takes the start is the first of two; the claim is sampled on the second.
         a_wait_reg <= CACHE_PRESENT ? CLAIM_DELAY - 2'h1 : 2'h0;
         a_claimed_reg <= !CACHE_PRESENT;
         a_taken_reg <= 1'b0;
         a_aacked_reg <= 1'b0;
      end else if (a_valid_reg) begin
         if (!a_claimed_reg) begin
            if (a_wait_reg == 2'h1) begin
               a_claimed_reg <= CACHE_CLAIM_N;
               a_valid_reg <= CACHE_CLAIM_N;
            end
            a_wait_reg <= a_wait_reg - 2'h1;
         end
         if (eng_take) begin
            a_taken_reg <= 1'b1;
         end
         if (address_acknowledge_n_now) begin
            a_aacked_reg <= 1'b1;
         end
         if (a_aacked_reg) begin
            a_valid_reg <= 1'b0;
         end
      end
   end

   // Request fields are caught with the transfer start.
   always_ff @(posedge CLK) begin
      if (!a_valid_reg && !TRANSFER_START_N) begin
         a_addr_reg <= ADDR;
         a_read_reg <= READ;
         a_burst_reg <= BURST;
         a_be_reg <= BYTE_EN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Data tenure.

   assign rd_ta = dt_active_reg && dt_read_reg && buf_out_valid && !DATA_BUS_GRANT_N;
   assign wr_ta = dt_active_reg && !dt_read_reg && e_wr_reg && buf_in_ready && !DATA_BUS_GRANT_N;
   assign ta_now = rd_ta || wr_ta;
   assign TA_N = !ta_now;
   assign DATA_OE = rd_ta;
   assign DATA_OUT = buf_out_data[DATA_W-1:0];
   assign DATA_LANE_PARITY = buf_out_data[SD_W-1:DATA_W];

   // A tenure opens only when the retry window closes without a retry.
   always_ff @(posedge CLK) begin
      if (RST) begin
         dt_active_reg <= 1'b0;
         dt_read_reg <= 1'b0;
         dt_left_reg <= 3'h0;
      end else if (a_valid_reg && a_aacked_reg && ADDRESS_RETRY_N) begin
         dt_active_reg <= 1'b1;
         dt_read_reg <= a_read_reg;
         dt_left_reg <= a_burst_reg ? BURST_BEATS : SINGLE_BEATS;
      end else if (ta_now) begin
         dt_left_reg <= dt_left_reg - 3'h1;
         dt_active_reg <= !dt_last_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // SDRAM access engine.

   assign e_bank = e_addr_reg[BANK_LSB +: 2];
   assign page_hit = open_v_reg[s_bank] && (open_blk_reg[s_bank] == s_blk) &&
      (open_row_reg[s_bank] == a_addr_reg[ROW_LSB +: ROW_W]);
   // A write may only take the shared buffer once reads have fully drained.
   assign wr_clear = (buf_count == 2'h0) && (rd_pipe_reg == '0) && !(dt_active_reg && dt_read_reg);
   // Taking the next request while the last tenure still runs starts its SDRAM access early.
   assign eng_take = (e_state_reg == E_IDLE) && a_valid_reg && a_claimed_reg && !a_taken_reg &&
      (a_read_reg || wr_clear);
   assign rd_arrive = rd_pipe_reg[RD_PIPE-1];
   assign inflight = 3'($countones(rd_pipe_reg));
   // Read credits widen while the data bus is granted so beats stream back to back.
   assign rd_room = ({1'b0, buf_count} + inflight) < (DATA_BUS_GRANT_N ? CREDIT_IDLE : CREDIT_GRANT);

   // Command choice for the current state and timers.
   always_comb begin
      cmd = CMD_NOP;
      issue_rd = 1'b0;
      issue_wr = 1'b0;
      blk_sel = e_addr_reg[BLK_LSB +: 3];
      ba_sel = e_bank;
      a_sel = {5'h00, e_addr_reg[COL_LSB+2 +: COL_W-2], 2'(e_addr_reg[COL_LSB +: 2] + e_issued_reg[1:0])};
      case (e_state_reg)
         E_PRE: begin
            if (act_cnt_reg >= T_RAS && wr_cnt_reg >= T_WR) begin
               cmd = CMD_PRE;
               blk_sel = open_blk_reg[e_bank];
            end
         end
         E_ACT: begin
            if (pre_cnt_reg >= T_RP && act_cnt_reg >= T_RC) begin
               cmd = CMD_ACT;
               a_sel = e_addr_reg[ROW_LSB +: ROW_W];
            end
         end
         E_RMW: begin
            if (act_cnt_reg >= T_RCD && !rmw_sent_reg) begin
               cmd = CMD_READ;
            end
         end
         E_RW: begin
            if (!e_abort_reg && act_cnt_reg >= T_RCD) begin
               if (e_read_reg && e_issued_reg < e_beats_reg && dt_active_reg && dt_read_reg &&
                   !DATA_BUS_GRANT_N && rd_room) begin
                  cmd = CMD_READ;
                  issue_rd = 1'b1;
               end else if (!e_read_reg && buf_out_valid) begin
                  cmd = CMD_WRITE;
                  issue_wr = 1'b1;
               end
            end
         end
         default: cmd = CMD_NOP;
      endcase
   end

   // Engine sequence; a page hit goes straight to column commands.
   always_ff @(posedge CLK) begin
      if (RST) begin
         e_state_reg <= E_IDLE;
         e_wr_reg <= 1'b0;
         e_abort_reg <= 1'b0;
         rmw_sent_reg <= 1'b0;
         e_issued_reg <= 3'h0;
      end else begin
         case (e_state_reg)
            E_IDLE: begin
               if (eng_take) begin
                  e_addr_reg <= a_addr_reg;
                  e_read_reg <= a_read_reg;
                  e_be_reg <= a_be_reg;
                  e_beats_reg <= a_burst_reg ? BURST_BEATS : SINGLE_BEATS;
                  e_issued_reg <= 3'h0;
                  e_abort_reg <= 1'b0;
                  rmw_sent_reg <= 1'b0;
                  e_wr_reg <= !a_read_reg;
                  if (page_hit) begin
                     e_state_reg <= (!a_read_reg && !a_burst_reg) ? E_RMW : E_RW;
                  end else begin
                     e_state_reg <= open_v_reg[s_bank] ? E_PRE : E_ACT;
                  end
               end
            end
            E_PRE: begin
               if (cmd == CMD_PRE) begin
                  e_state_reg <= E_ACT;
               end
            end
            E_ACT: begin
               if (cmd == CMD_ACT) begin
                  e_state_reg <= (!e_read_reg && e_beats_reg == SINGLE_BEATS) ? E_RMW : E_RW;
               end
            end
            E_RMW: begin
               if (cmd == CMD_READ) begin
                  rmw_sent_reg <= 1'b1;
               end
               if (rd_arrive) begin
                  e_state_reg <= E_RW;
               end
            end
            E_RW: begin
               if (e_abort_reg || ((issue_rd || issue_wr) && e_issued_reg == e_beats_reg - 3'h1)) begin
                  e_state_reg <= E_IDLE;
                  e_wr_reg <= 1'b0;
               end
               if (issue_rd || issue_wr) begin
                  e_issued_reg <= e_issued_reg + 3'h1;
               end
            end
            default: e_state_reg <= E_IDLE;
         endcase
         if (a_valid_reg && a_aacked_reg && !ADDRESS_RETRY_N) begin
            e_abort_reg <= 1'b1;
         end
      end
   end

   // The read half of a single-beat write lands here for merging.
   always_ff @(posedge CLK) begin
      if (e_state_reg == E_RMW && rd_arrive) begin
         merge_reg <= SD_DQ_IN[DATA_W-1:0];
      end
   end

   // Timers since the last activate, precharge and write; pipe of reads in flight.
   always_ff @(posedge CLK) begin
      if (RST) begin
         act_cnt_reg <= CNT_SAT;
         pre_cnt_reg <= CNT_SAT;
         wr_cnt_reg <= CNT_SAT;
         rd_pipe_reg <= '0;
      end else begin
         act_cnt_reg <= (cmd == CMD_ACT) ? 4'h1 : (act_cnt_reg == CNT_SAT ? CNT_SAT : act_cnt_reg + 4'h1);
         pre_cnt_reg <= (cmd == CMD_PRE) ? 4'h1 : (pre_cnt_reg == CNT_SAT ? CNT_SAT : pre_cnt_reg + 4'h1);
         wr_cnt_reg <= (cmd == CMD_WRITE) ? 4'h1 : (wr_cnt_reg == CNT_SAT ? CNT_SAT : wr_cnt_reg + 4'h1);
         rd_pipe_reg <= {rd_pipe_reg[RD_PIPE-2:0], cmd == CMD_READ};
      end
   end

   // Open rows stay recorded per bank until precharged.
   always_ff @(posedge CLK) begin
      if (RST) begin
         open_v_reg <= '0;
         for (int i = 0; i < NUM_BANKS; i++) begin
            open_blk_reg[i] <= 3'h0;
            open_row_reg[i] <= '0;
         end
      end else if (cmd == CMD_ACT) begin
         open_v_reg[e_bank] <= 1'b1;
         open_blk_reg[e_bank] <= e_addr_reg[BLK_LSB +: 3];
         open_row_reg[e_bank] <= e_addr_reg[ROW_LSB +: ROW_W];
      end else if (cmd == CMD_PRE) begin
         open_v_reg[e_bank] <= 1'b0;
      end
   end

   // Write data merge, check byte and read parity per lane.
   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         wdata[8*i +: 8] = (e_beats_reg == SINGLE_BEATS && !e_be_reg[i]) ? merge_reg[8*i +: 8] :
            buf_out_data[8*i +: 8];
         chk[i] = ~^wdata[8*i +: 8];
         gen_par[i] = (~^SD_DQ_IN[8*i +: 8]) ^ FORCE_EVEN_PARITY[i];
      end
   end

   // SDRAM pins are registered; one chip select per 72-bit block.
   always_ff @(posedge CLK) begin
      if (RST) begin
         SD_CMD <= CMD_NOP;
         SD_CS_N <= 8'hFF;
         SD_BA <= 2'h0;
         SD_A <= '0;
         SD_DQ_OUT <= '0;
         SD_DQ_OE <= 1'b0;
      end else begin
         SD_CMD <= cmd;
         SD_CS_N <= (cmd == CMD_NOP) ? 8'hFF : ~(8'h01 << blk_sel);
         SD_BA <= ba_sel;
         SD_A <= a_sel;
         SD_DQ_OUT <= {chk, wdata};
         SD_DQ_OE <= issue_wr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared data buffer: bus writes fill it toward SDRAM, SDRAM reads fill it toward the bus.

   assign buf_in_valid = e_wr_reg ? wr_ta : (rd_arrive && e_state_reg != E_RMW);
   assign buf_in_data = e_wr_reg ? {DATA_LANE_PARITY_IN, DATA_IN} : {gen_par, SD_DQ_IN[DATA_W-1:0]};
   assign buf_out_ready = e_wr_reg ? issue_wr : rd_ta;

   mc_pair_buf #(.W(SD_W)) data_buf (
      .clk(CLK),
      .rst(RST),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(buf_in_data),
      .out_valid(buf_out_valid),
      .out_ready(buf_out_ready),
      .out_data(buf_out_data),
      .count(buf_count)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Bus parity checking and logging.

   // Lanes with even parity raise errors.
   always_comb begin
      for (int i = 0; i < LANES; i++) begin
         dpar_err[i] = (wr_ta || (CHECK_ALL_PARITY && !BUS_TA_N && !rd_ta)) &&
            !(^{DATA_IN[8*i +: 8], DATA_LANE_PARITY_IN[i]});
      end
      for (int j = 0; j < ADDR_LANES; j++) begin
         apar_err[j] = !TRANSFER_START_N && !(^{ADDR[8*j +: 8], ADDRESS_LANE_PARITY[j]});
      end
   end

   // Logs are sticky; a new error wins over a clear in the same cycle.
   always_ff @(posedge CLK) begin
      if (RST) begin
         apar_log_reg <= '0;
         dpar_log_reg <= '0;
         MCHECK_N <= 1'b1;
      end else begin
         apar_log_reg <= apar_err | (apar_log_reg & {ADDR_LANES{!PARITY_LOG_CLR}});
         dpar_log_reg <= dpar_err | (dpar_log_reg & {LANES{!PARITY_LOG_CLR}});
         MCHECK_N <= !(MCHECK_EN && (|apar_log_reg || |dpar_log_reg));
      end
   end

   assign ADDR_PARITY_LOG = apar_log_reg;
   assign DATA_PARITY_LOG = dpar_log_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.

   a_idle_address_acknowledge_n: assert property (@(posedge CLK) disable iff (RST)
      (a_valid_reg && a_claimed_reg && a_taken_reg && !a_aacked_reg && !dt_active_reg && !OTHER_DATA_BUSY)
      |-> !ADDRESS_ACKNOWLEDGE_N) else $error("address not acknowledged on idle bus");
   a_other_holdoff: assert property (@(posedge CLK) disable iff (RST)
      (OTHER_DATA_BUSY && !dt_active_reg) |-> ADDRESS_ACKNOWLEDGE_N) else $error("acknowledge during other tenure");
   a_retry_no_ta: assert property (@(posedge CLK) disable iff (RST)
      (a_aacked_reg && !ADDRESS_RETRY_N) |=> TA_N [*3]) else $error("data moved after retry");
   a_rcd_gap: assert property (@(posedge CLK) disable iff (RST)
      (SD_CMD == CMD_ACT) |=> (SD_CMD != CMD_READ && SD_CMD != CMD_WRITE)) else $error("column command too soon");
   a_ras_gap: assert property (@(posedge CLK) disable iff (RST)
      (SD_CMD == CMD_ACT) |=> (SD_CMD != CMD_PRE) [*4]) else $error("precharge before active time");
   a_hit_no_act: assert property (@(posedge CLK) disable iff (RST)
      (eng_take && page_hit) |=> (SD_CMD != CMD_ACT) [*2]) else $error("activate on page hit");
   a_claim_ignore: assert property (@(posedge CLK) disable iff (RST)
      (a_valid_reg && !a_claimed_reg && a_wait_reg == 2'h1 && !CACHE_CLAIM_N) |=> !a_valid_reg && ADDRESS_ACKNOWLEDGE_N)
      else $error("claimed cycle not ignored");
   a_burst_stream: assert property (@(posedge CLK) disable iff (RST)
      (rd_ta && dt_left_reg == BURST_BEATS) |=> (!TA_N || DATA_BUS_GRANT_N) [*3]) else $error("gap inside read burst");
   a_dpar_log: assert property (@(posedge CLK) disable iff (RST)
      (wr_ta && !(^{DATA_IN[7:0], DATA_LANE_PARITY_IN[0]})) |=> DATA_PARITY_LOG[0]) else $error("lane error not logged");
endmodule

// file: tb_system_memory_controller.sv
// Self-checking bench for the memory controller front end.
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; $display("Error t=%0t %h %h", $time, g, e); end end
module tb_system_memory_controller;
   import mc_pkg::*;
   logic clk, rst, claim_n, cache_on, chk_all, mck_en, log_clr, start_n, rd, burst, coh_n, retry_n, ack_n, ta_n, oe;
   logic mck_n, seen_rd, wr_ok, grant_n, other_busy, bus_ta_n, sd_oe;
   logic [31:0] addr;
   logic [3:0] apar, apar_log;
   logic [63:0] wdata, dout;
   logic [7:0] dp, dpo, dp_log, cs_n, force_even;
   logic [71:0] sd_in, sd_out;
   logic [2:0] cmd;
   int failures, tests_run, ta_cnt, ta_first, ta_last, cyc, acts;
   typedef struct packed {logic [3:0] bap; logic [7:0] frc; logic mck;} row_t;
   row_t rows [4] = '{'{4'h0, 8'h00, 1'b1}, '{4'h1, 8'h81, 1'b0}, '{4'h4, 8'h0F, 1'b0}, '{4'h8, 8'hF0, 1'b0}};
   system_memory_controller dut (.CLK(clk), .RST(rst), .TRANSFER_START_N(start_n), .ADDR(addr),
      .ADDRESS_LANE_PARITY(apar), .READ(rd), .BURST(burst), .BYTE_EN(8'hFF), .GLOBAL_COHERENT_N(coh_n),
      .CACHE_CLAIM_N(claim_n), .ADDRESS_RETRY_N(retry_n), .ADDRESS_ACKNOWLEDGE_N(ack_n), .DATA_BUS_GRANT_N(grant_n),
      .OTHER_DATA_BUSY(other_busy), .BUS_TA_N(bus_ta_n), .DATA_IN(wdata), .DATA_LANE_PARITY_IN(dp), .TA_N(ta_n),
      .DATA_OE(oe), .DATA_OUT(dout), .DATA_LANE_PARITY(dpo), .CACHE_PRESENT(cache_on),
      .FORCE_EVEN_PARITY(force_even), .CHECK_ALL_PARITY(chk_all), .MCHECK_EN(mck_en), .PARITY_LOG_CLR(log_clr),
      .ADDR_PARITY_LOG(apar_log), .DATA_PARITY_LOG(dp_log), .MCHECK_N(mck_n), .SD_CS_N(cs_n), .SD_CMD(cmd),
      .SD_BA(), .SD_A(), .SD_DQ_OUT(sd_out), .SD_DQ_OE(sd_oe), .SD_DQ_IN(sd_in));
   bus_master_model m (.clk(clk), .ack_n(ack_n), .start_n(start_n), .addr(addr), .apar(apar), .rd(rd),
      .burst(burst), .coh_n(coh_n), .retry_n(retry_n), .wdata(wdata), .dp(dp));
   // Clock at 200 MHz.
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // Records beats and commands; memory data changes every cycle.
   always @(posedge clk) begin
      cyc++;
      sd_in <= {sd_in[70:0], ~sd_in[71]};
      if (!(&cs_n)) begin
         acts += (cmd === CMD_ACT);
         seen_rd |= (cmd === CMD_READ);
         if (cmd === CMD_WRITE) wr_ok = seen_rd;
      end
      if (ta_n === 1'b0) begin
         ta_cnt++;
         if (ta_cnt == 1) ta_first = cyc;
         ta_last = cyc;
         `CHK(oe, rd)
         for (int i = 0; i < 8; i++) if (oe) `CHK(dpo[i], ~^dout[8*i+:8] ^ force_even[i])
      end
      for (int i = 0; i < 8; i++) if (sd_oe) `CHK(sd_out[64+i], ~^sd_out[8*i+:8])
   end
   // Runs one tenure and lets its data phase finish.
   task automatic run(input logic [31:0] a, input logic r, b, input logic [3:0] bap, input logic [7:0] bdp,
      input logic rt);
      ta_cnt = 0;
      seen_rd = 1'b0;
      wr_ok = 1'b0;
      m.issue(a, r, b, bap, bdp, rt);
      repeat (16) @(posedge clk);
      #1;
   endtask
   // Clears both parity logs.
   task automatic clr();
      log_clr = 1'b1;
      @(posedge clk);
      #1;
      log_clr = 1'b0;
   endtask
   // Prints the counts and the verdict.
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Cuts a hang short.
   initial begin
      #(5 * 3000);
      failures++;
      tally_and_finish();
   end
   // Main sequence: reset, table of same-page burst reads (the first opens the row), then the awkward cases.
   initial begin
      {rst, claim_n, cache_on, chk_all, mck_en, log_clr, force_even, sd_in} = {6'h32, 80'h0};
      {grant_n, other_busy, bus_ta_n} = 3'h1;
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
      `CHK({ack_n, ta_n, mck_n, apar_log, dp_log, cmd, cs_n}, {3'h7, 12'h000, CMD_NOP, 8'hFF})
      foreach (rows[k]) begin
         force_even = rows[k].frc;
         run(32'h0000_1008, 1'b1, 1'b1, rows[k].bap, 8'h00, 1'b0);
         `CHK(apar_log, rows[k].bap)
         `CHK(mck_n, rows[k].mck)
         `CHK({ta_cnt, ta_last - ta_first}, {32'd4, 32'd3})
         clr();
      end
      run(32'h0000_1010, 1'b0, 1'b0, 4'h0, 8'h08, 1'b0);
      `CHK({wr_ok, dp_log, mck_n}, {1'b1, 8'h08, 1'b0})
      run(32'h0000_1010, 1'b0, 1'b1, 4'h0, 8'h00, 1'b0);
      `CHK({wr_ok, dp_log}, {1'b0, 8'h08})
      `CHK(acts, 1)
      for (int c = 0; c < 2; c++) begin
         clr();
         chk_all = c[0];
         run(32'h0000_1008, 1'b1, 1'b0, 4'h0, 8'h01, 1'b0);
         // Another slave's beat carries the bad lane; only the check-all option may log it.
         bus_ta_n = 1'b0;
         @(posedge clk);
         #1;
         bus_ta_n = 1'b1;
         `CHK(dp_log, {7'h00, c[0]})
      end
      run(32'h0000_1008, 1'b1, 1'b1, 4'h0, 8'h00, 1'b1);
      `CHK(ta_cnt, 0)
      // A foreign tenure holds off the acknowledge, a withheld grant holds off the beats.
      for (int c = 0; c < 2; c++) begin
         {other_busy, grant_n} = c[0] ? 2'h1 : 2'h2;
         run(32'h0000_1008, 1'b1, 1'b1, 4'h0, 8'h00, 1'b0);
         `CHK(ta_cnt, 0)
         {other_busy, grant_n} = 2'h0;
         repeat (16) @(posedge clk);
         #1;
         `CHK(ta_cnt, 4)
      end
      cache_on = 1'b1;
      for (int c = 0; c < 2; c++) begin
         claim_n = c[0];
         run(32'h0000_1008, 1'b1, 1'b1, 4'h0, 8'h00, 1'b0);
         `CHK(ta_cnt, 4 * c)
      end
      tally_and_finish();
   end
endmodule
